// ### common/pcl_pkg.sv
// package: register map, field positions and timing constants of the power-on-clear and low-voltage block
package pcl_pkg;

    // register byte offsets
    localparam logic [7:0] PCL_CTRL_OFS    = 8'h00;
    localparam logic [7:0] PCL_LEVEL_OFS   = 8'h04;
    localparam logic [7:0] PCL_CAUSE_OFS   = 8'h08;
    localparam logic [7:0] PCL_IRQ_ST_OFS  = 8'h0C;
    localparam logic [7:0] PCL_IRQ_EN_OFS  = 8'h10;
    localparam logic [7:0] PCL_IRQ_CLR_OFS = 8'h14;
    localparam logic [7:0] PCL_STATUS_OFS  = 8'h18;

    // detector control register fields
    localparam int CTRL_FLAG_BIT   = 0;
    localparam int CTRL_ACTION_BIT = 1;
    localparam int CTRL_SOURCE_BIT = 2;
    localparam int CTRL_ENABLE_BIT = 7;

    // reset cause register
    localparam int CAUSE_LOWVOLT_BIT = 0;

    // status register bits
    localparam int STAT_POC_BIT    = 0;
    localparam int STAT_HIGH_BIT   = 1;
    localparam int STAT_STAB_BIT   = 2;

    // interrupt status bits
    localparam int IRQ_FALL_BIT = 0;
    localparam int IRQ_RISE_BIT = 1;
    localparam int IRQ_W        = 2;

    localparam int LEVEL_W = 4;

    localparam logic [31:0] PCL_RESET_VAL = 32'h0000_0000;

    // clock and stabilisation wait
    localparam int CLK_MHZ         = 100;
    localparam int STAB_MIN_US     = 1930;
    localparam int STAB_MAX_US     = 5390;
    localparam int STAB_MIN_CYC    = STAB_MIN_US * CLK_MHZ;
    localparam int STAB_MAX_CYC    = STAB_MAX_US * CLK_MHZ;
    localparam int DET_SETTLE_US   = 10;
    localparam int DET_SETTLE_CYC  = DET_SETTLE_US * CLK_MHZ;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        PCL_ST_HOLD   = 2'b00,
        PCL_ST_WAITHI = 2'b01,
        PCL_ST_STAB   = 2'b10,
        PCL_ST_RUN    = 2'b11
    } pcl_state_t;

endpackage : pcl_pkg

// ### hdl/pcl_sync3.sv
// three-stage synchroniser with agreement filter for asynchronous comparator levels
`timescale 1ns/1ps
`default_nettype none
module pcl_sync3 #(
    parameter logic INIT = 1'b0
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic async_in,
    output var  logic sync_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // first stage feeds only the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_out <= INIT;
        end else if (s2_q == s3_q) begin
            sync_out <= s3_q;
        end
    end
endmodule : pcl_sync3
`default_nettype wire

// ### hdl/pcl_top.sv
// power-on-clear sequencing and low-voltage detector control with AHB-Lite registers
//
// How it works
// - with the threshold option at 0, reset is held at power-up and while supply is below the low threshold, and released at or above it.
// - with the threshold option at 1, reset asserts below the low threshold and releases only once supply reaches the high threshold.
// - a fast climb from low to high threshold inserts an automatic stabilisation wait of at most the maximum time before release.
// - control bit 2 chooses whether the detector watches the supply or the external detect input.
// - with action bit at 1, internal reset is held while the selected voltage is below threshold and released at or above it.
// - with action bit 1 at 0, every crossing in either direction after the settling time raises an interrupt.
// - a four-bit level value, written by software, drives the comparator level selector among sixteen levels.
// - the detector keeps running and producing reset or interrupt in STOP mode.
// - control bit 0 reads whether the selected voltage is currently below threshold while the detector runs.
// - a detector reset sets bit 0 of the reset cause register.
// - the enable bit starts the comparator; edge interrupts are taken only after a settling time, the flag counts at once.
// - enable, action and source bits clear on every reset except a detector reset.
// - with detector enabled and interrupt action chosen, the flag drives lowvolt_interrupt; irq follows the enabled edge status bits.
// - a power-on-clear reset clears the whole reset cause register.
`timescale 1ns/1ps
`default_nettype none
module pcl_top
    import pcl_pkg::*;
#(
    parameter int STAB_CYCLES   = STAB_MIN_CYC,
    parameter int STAB_MAX      = STAB_MAX_CYC,
    parameter int SETTLE_CYCLES = DET_SETTLE_CYC
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [7:0]         haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output var  logic [31:0]        hrdata,
    output var  logic               hreadyout,
    output var  logic               hresp,
    // analog comparator results, asynchronous, high means below threshold
    input  wire logic               supply_below_low,
    input  wire logic               supply_below_high,
    input  wire logic               supply_below_level,
    input  wire logic               ext_below_ref,
    // option byte and power state
    input  wire logic               powerup_threshold_select,
    input  wire logic               stop_mode,
    // outputs
    output var  logic [LEVEL_W-1:0] detect_level,
    output var  logic               detector_enable,
    output var  logic               detect_source_select,
    output var  logic               internal_reset_n,
    output var  logic               lowvolt_interrupt,
    output var  logic               irq
);

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers
    logic low_s;
    logic high_s;
    logic lvl_s;
    logic ext_s;

    pcl_sync3 #(.INIT(1'b1)) u_sync_low  (.hclk(hclk), .hresetn(hresetn),
                                          .async_in(supply_below_low),   .sync_out(low_s));
    pcl_sync3 #(.INIT(1'b1)) u_sync_high (.hclk(hclk), .hresetn(hresetn),
                                          .async_in(supply_below_high),  .sync_out(high_s));
    pcl_sync3 #(.INIT(1'b0)) u_sync_lvl  (.hclk(hclk), .hresetn(hresetn),
                                          .async_in(supply_below_level), .sync_out(lvl_s));
    pcl_sync3 #(.INIT(1'b0)) u_sync_ext  (.hclk(hclk), .hresetn(hresetn),
                                          .async_in(ext_below_ref),      .sync_out(ext_s));

    ////////////////////////////////////////////////////////////////////////////
    // power-on-clear sequencer
    pcl_state_t  state_q;
    logic [31:0] stab_cnt_q;
    logic [31:0] fast_cnt_q;
    logic        option_q;

    // option latched by a clocked process while the sequencer is in PCL_ST_HOLD
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            option_q <= 1'b0;
        end else if (state_q == PCL_ST_HOLD) begin
            option_q <= powerup_threshold_select;
        end
    end

    // poc_hold also follows the raw low comparator so a brown-out asserts reset at once
    logic poc_hold;
    assign poc_hold = (state_q != PCL_ST_RUN) || supply_below_low;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q    <= PCL_ST_HOLD;
            stab_cnt_q <= 32'h0000_0000;
            fast_cnt_q <= 32'h0000_0000;
        end else begin
            unique case (state_q)
                PCL_ST_HOLD: begin
                    fast_cnt_q <= 32'h0000_0000;
                    if (!low_s) begin
                        state_q <= option_q ? PCL_ST_WAITHI : PCL_ST_RUN;
                    end
                end
                PCL_ST_WAITHI: begin
                    fast_cnt_q <= fast_cnt_q + 32'h0000_0001;
                    if (low_s) begin
                        state_q <= PCL_ST_HOLD;
                    end else if (!high_s) begin
                        // climb faster than the minimum: insert the stabilisation wait
                        if (fast_cnt_q < 32'(STAB_CYCLES)) begin
                            stab_cnt_q <= 32'(STAB_CYCLES) - fast_cnt_q;
                            state_q    <= PCL_ST_STAB;
                        end else begin
                            state_q    <= PCL_ST_RUN;
                        end
                    end
                end
                PCL_ST_STAB: begin
                    if (low_s) begin
                        state_q <= PCL_ST_HOLD;
                    end else if (stab_cnt_q <= 32'h0000_0001 ||
                                 stab_cnt_q > 32'(STAB_MAX)) begin
                        state_q <= PCL_ST_RUN;
                    end else begin
                        stab_cnt_q <= stab_cnt_q - 32'h0000_0001;
                    end
                end
                PCL_ST_RUN: begin
                    if (low_s) begin
                        state_q <= PCL_ST_HOLD;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // detector control (survives its own reset)
    logic               enable_q;
    logic               action_q;
    logic               source_q;
    logic [LEVEL_W-1:0] level_q;
    logic               cause_q;
    logic [IRQ_W-1:0]   irq_st_q;
    logic [IRQ_W-1:0]   irq_en_q;
    logic [31:0]        settle_q;

    // bus decode
    logic       ph_valid_q;
    logic       ph_write_q;
    logic [7:0] ph_addr_q;
    logic       wr_en;
    assign wr_en = ph_valid_q && ph_write_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = wr_en && (a[7:2] == ofs[7:2]);
    endfunction : hit

    // detector reset only from selected, enabled, reset-action comparison
    logic det_below;
    logic det_raw;
    logic det_rst;
    assign det_below = source_q ? ext_s : lvl_s;
    assign det_raw   = source_q ? ext_below_ref : supply_below_level;
    // raw comparator is used here on purpose: reset must not wait for the clock
    assign det_rst   = enable_q && action_q && (det_raw || det_below);

    // control bits held in a domain reset only by the external reset and poc
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_q <= 1'b0;
            action_q <= 1'b0;
            source_q <= 1'b0;
        end else if (poc_hold) begin
            enable_q <= 1'b0;
            action_q <= 1'b0;
            source_q <= 1'b0;
        end else if (hit(ph_addr_q, PCL_CTRL_OFS)) begin
            enable_q <= hwdata[CTRL_ENABLE_BIT];
            action_q <= hwdata[CTRL_ACTION_BIT];
            source_q <= hwdata[CTRL_SOURCE_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_q <= '0;
        end else if (poc_hold) begin
            level_q <= '0;
        end else if (hit(ph_addr_q, PCL_LEVEL_OFS)) begin
            level_q <= hwdata[LEVEL_W-1:0];
        end
    end

    // settle counter after enabling; stop_mode deliberately ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            settle_q <= 32'h0000_0000;
        end else if (!enable_q) begin
            settle_q <= 32'(SETTLE_CYCLES);
        end else if (settle_q != 32'h0000_0000) begin
            settle_q <= settle_q - 32'h0000_0001;
        end
    end

    logic flag;
    assign flag = enable_q && det_below;

    // edge detection on synchronised level, only after settling
    logic prev_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= det_below;
        end
    end

    logic [IRQ_W-1:0] ev;
    always_comb begin
        ev = '0;
        if (enable_q && !action_q && settle_q == 32'h0000_0000) begin
            ev[IRQ_FALL_BIT] = det_below && !prev_q;
            ev[IRQ_RISE_BIT] = !det_below && prev_q;
        end
    end

    // set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_st_q <= '0;
        end else if (hit(ph_addr_q, PCL_IRQ_CLR_OFS)) begin
            irq_st_q <= (irq_st_q & ~hwdata[IRQ_W-1:0]) | ev;
        end else begin
            irq_st_q <= irq_st_q | ev;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_en_q <= '0;
        end else if (hit(ph_addr_q, PCL_IRQ_EN_OFS)) begin
            irq_en_q <= hwdata[IRQ_W-1:0];
        end
    end

    // cause flag: poc clears, detector reset sets, software may clear by write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cause_q <= 1'b0;
        end else if (poc_hold) begin
            cause_q <= 1'b0;
        end else if (det_rst) begin
            cause_q <= 1'b1;
        end else if (hit(ph_addr_q, PCL_CAUSE_OFS)) begin
            cause_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            detect_level         <= '0;
            detector_enable      <= 1'b0;
            detect_source_select <= 1'b0;
            lowvolt_interrupt    <= 1'b0;
            irq                  <= 1'b0;
        end else begin
            detect_level         <= level_q;
            detector_enable      <= enable_q;
            detect_source_select <= source_q;
            lowvolt_interrupt    <= enable_q && !action_q && flag;
            irq                  <= |(irq_st_q & irq_en_q);
        end
    end

    // combined reset: asserted asynchronously, released on the clock once all sources clear
    logic rst_any;
    assign rst_any = poc_hold || det_rst;
    always_ff @(posedge hclk or negedge hresetn or posedge rst_any) begin
        if (!hresetn) begin
            internal_reset_n <= 1'b0;
        end else if (rst_any) begin
            internal_reset_n <= 1'b0;
        end else begin
            internal_reset_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid_q <= 1'b0;
            ph_write_q <= 1'b0;
            ph_addr_q  <= 8'h00;
        end else if (hready) begin
            ph_valid_q <= hsel && (htrans == HTRANS_NONSEQ);
            ph_write_q <= hwrite;
            ph_addr_q  <= haddr;
        end
    end

    logic [31:0] rd_d;
    always_comb begin
        rd_d = PCL_RESET_VAL;
        unique case (haddr[7:2])
            PCL_CTRL_OFS[7:2]: begin
                rd_d[CTRL_ENABLE_BIT] = enable_q;
                rd_d[CTRL_SOURCE_BIT] = source_q;
                rd_d[CTRL_ACTION_BIT] = action_q;
                rd_d[CTRL_FLAG_BIT]   = flag;
            end
            PCL_LEVEL_OFS[7:2]:  rd_d[LEVEL_W-1:0]      = level_q;
            PCL_CAUSE_OFS[7:2]:  rd_d[CAUSE_LOWVOLT_BIT] = cause_q;
            PCL_IRQ_ST_OFS[7:2]: rd_d[IRQ_W-1:0]        = irq_st_q;
            PCL_IRQ_EN_OFS[7:2]: rd_d[IRQ_W-1:0]        = irq_en_q;
            PCL_STATUS_OFS[7:2]: begin
                rd_d[STAT_POC_BIT]  = poc_hold;
                rd_d[STAT_HIGH_BIT] = option_q;
                rd_d[STAT_STAB_BIT] = (state_q == PCL_ST_STAB);
            end
            default: rd_d = PCL_RESET_VAL;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
                hrdata <= rd_d;
            end
        end
    end

endmodule : pcl_top
`default_nettype wire

// ### verification/pcl_top_props.sv
// checker: port properties of the power-on-clear block
`timescale 1ns/1ps
`default_nettype none
module pcl_top_props
    import pcl_pkg::*;
(
    input wire logic               hclk,
    input wire logic               hresetn,
    input wire logic               hsel,
    input wire logic [7:0]         haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic [31:0]        hwdata,
    input wire logic               hready,
    input wire logic               hreadyout,
    input wire logic               hresp,
    input wire logic               supply_below_low,
    input wire logic               supply_below_high,
    input wire logic               supply_below_level,
    input wire logic               ext_below_ref,
    input wire logic               powerup_threshold_select,
    input wire logic [LEVEL_W-1:0] detect_level,
    input wire logic               detector_enable,
    input wire logic               detect_source_select,
    input wire logic               internal_reset_n,
    input wire logic               lowvolt_interrupt,
    input wire logic               irq
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic wr_any;
    logic wr_ctrl;
    logic wr_level;

    // writes count only outside internal reset
    assign wr_any   = hsel && hready && htrans == HTRANS_NONSEQ && hwrite && internal_reset_n;
    assign wr_ctrl  = wr_any && haddr == PCL_CTRL_OFS;
    assign wr_level = wr_any && haddr == PCL_LEVEL_OFS;

    a_poc_async_hold: assert property (supply_below_low |-> !internal_reset_n)
        else $error("reset not held below low threshold");
    a_release_supply_ok: assert property ($rose(internal_reset_n) |-> !supply_below_low)
        else $error("release below low threshold");
    a_high_thresh_hold: assert property ($fell(supply_below_low) && powerup_threshold_select
        && supply_below_high |=> !internal_reset_n)
        else $error("reset released before high threshold");
    a_poc_clears_ctrl: assert property (supply_below_low [*8] |->
        !detector_enable && !detect_source_select && !lowvolt_interrupt)
        else $error("control bits survive power-on clear");
    a_lvint_needs_enable: assert property (lowvolt_interrupt |->
        detector_enable || $past(detector_enable))
        else $error("interrupt without enable");
    a_lvint_idle_low: assert property ((!supply_below_level && !ext_below_ref) [*8] |->
        !lowvolt_interrupt)
        else $error("interrupt with no source low");
    a_level_write: assert property (wr_level ##1 internal_reset_n |->
        (##1 detect_level == $past(hwdata[3:0])) or (##2 detect_level == $past(hwdata[3:0], 2)))
        else $error("level output misses write");
    a_ctrl_write: assert property (wr_ctrl ##1 internal_reset_n |->
        (##1 {detector_enable, detect_source_select} == {$past(hwdata[7]), $past(hwdata[2])})
        or (##2 {detector_enable, detect_source_select} == {$past(hwdata[7], 2), $past(hwdata[2], 2)}))
        else $error("control outputs miss write");
    a_reset_clears: assert property ($rose(hresetn) |-> !internal_reset_n && !irq
        && !lowvolt_interrupt && !detector_enable && detect_level == '0)
        else $error("outputs not cleared by bus reset");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or okay");
endmodule : pcl_top_props

bind pcl_top pcl_top_props u_props (.*);
`default_nettype wire

// ### verification/pcl_top_tb.sv
// testbench: bus, reset sequencing, detector and interrupt scenarios of the power-on-clear block
`timescale 1ns/1ps
`default_nettype none
module pcl_top_tb
    import pcl_pkg::*;
;
    localparam int SETTLE = 5;
    localparam int SMAX   = 60;

    logic               hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0]         haddr;
    logic [1:0]         htrans;
    logic [2:0]         hsize;
    logic [31:0]        hwdata, hrdata, rd;
    logic               supply_below_low, supply_below_high, supply_below_level, ext_below_ref;
    logic               powerup_threshold_select, stop_mode, detector_enable;
    logic               detect_source_select, internal_reset_n, lowvolt_interrupt, irq;
    logic [LEVEL_W-1:0] detect_level;
    int                 err_count, comparisons, cycles, n;

    // single slave: its ready is the bus ready
    assign hready = hreadyout;

    pcl_top #(.STAB_CYCLES(20), .STAB_MAX(SMAX), .SETTLE_CYCLES(SETTLE)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .supply_below_low(supply_below_low),
        .supply_below_high(supply_below_high), .supply_below_level(supply_below_level),
        .ext_below_ref(ext_below_ref), .powerup_threshold_select(powerup_threshold_select),
        .stop_mode(stop_mode), .detect_level(detect_level), .detector_enable(detector_enable),
        .detect_source_select(detect_source_select), .internal_reset_n(internal_reset_n),
        .lowvolt_interrupt(lowvolt_interrupt), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // entered just after a rising edge; single word transfer, waits on ready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask : rdchk

    task automatic wait_rn(input logic v, input int lim);
        n = 0;
        while (internal_reset_n !== v && n < lim) begin
            @(posedge hclk);
            n++;
        end
        chk("internal_reset_n", {31'h0, internal_reset_n}, {31'h0, v});
    endtask : wait_rn

    task automatic bit_is(input string what, input logic seen, input logic exp);
        chk(what, {31'h0, seen}, {31'h0, exp});
    endtask : bit_is

    ////////////////////////////////////////////////////////////////////////////////
    task automatic s_reset;
        wait_rn(1'b1, 40);
        rdchk("ctrl", PCL_CTRL_OFS, 32'h0);
        rdchk("level", PCL_LEVEL_OFS, 32'h0);
        rdchk("cause", PCL_CAUSE_OFS, 32'h0);
        bus(1'b1, 8'h40, 32'hFFFF_FFFF);
        rdchk("unmapped", 8'h40, 32'h0);
    endtask : s_reset

    task automatic s_flag;
        stop_mode <= 1'b1;
        bus(1'b1, PCL_CTRL_OFS, 32'h80);
        repeat (SETTLE + 8) @(posedge hclk);
        supply_below_level <= 1'b1;
        repeat (8) @(posedge hclk);
        rdchk("flag_supply", PCL_CTRL_OFS, 32'h81);
        supply_below_level <= 1'b0;
        ext_below_ref      <= 1'b1;
        repeat (8) @(posedge hclk);
        rdchk("flag_unselected", PCL_CTRL_OFS, 32'h80);
        bus(1'b1, PCL_CTRL_OFS, 32'h84);
        repeat (8) @(posedge hclk);
        rdchk("flag_ext", PCL_CTRL_OFS, 32'h85);
        bit_is("source_out", detect_source_select, 1'b1);
        ext_below_ref <= 1'b0;
    endtask : s_flag

    task automatic s_irq;
        bus(1'b1, PCL_IRQ_EN_OFS, 32'h3);
        bus(1'b1, PCL_CTRL_OFS, 32'h80);
        repeat (SETTLE + 8) @(posedge hclk);
        bus(1'b1, PCL_IRQ_CLR_OFS, 32'h3);
        rdchk("irq_idle", PCL_IRQ_ST_OFS, 32'h0);
        supply_below_level <= 1'b1;
        repeat (8) @(posedge hclk);
        bit_is("lv_int_on", lowvolt_interrupt, 1'b1);
        bit_is("irq_on", irq, 1'b1);
        rdchk("irq_fall", PCL_IRQ_ST_OFS, 32'h1);
        supply_below_level <= 1'b0;
        repeat (8) @(posedge hclk);
        bit_is("lv_int_off", lowvolt_interrupt, 1'b0);
        rdchk("irq_both", PCL_IRQ_ST_OFS, 32'h3);
        bus(1'b1, PCL_IRQ_CLR_OFS, 32'h1);
        rdchk("irq_clr_one", PCL_IRQ_ST_OFS, 32'h2);
        bus(1'b1, PCL_IRQ_EN_OFS, 32'h1);
        repeat (3) @(posedge hclk);
        bit_is("irq_masked", irq, 1'b0);
        bus(1'b1, PCL_IRQ_CLR_OFS, 32'h2);
        rdchk("irq_cleared", PCL_IRQ_ST_OFS, 32'h0);
    endtask : s_irq

    task automatic s_lvreset;
        bus(1'b1, PCL_LEVEL_OFS, 32'hA);
        repeat (2) @(posedge hclk);
        chk("level_out", {28'h0, detect_level}, 32'hA);
        bus(1'b1, PCL_CTRL_OFS, 32'h82);
        repeat (SETTLE + 4) @(posedge hclk);
        supply_below_level <= 1'b1;
        wait_rn(1'b0, 10);
        supply_below_level <= 1'b0;
        wait_rn(1'b1, 20);
        rdchk("cause_lv", PCL_CAUSE_OFS, 32'h1);
        rdchk("ctrl_kept", PCL_CTRL_OFS, 32'h82);
        bus(1'b1, PCL_CTRL_OFS, 32'h86);
        ext_below_ref <= 1'b1;
        wait_rn(1'b0, 10);
    endtask : s_lvreset

    // power-on clear arrives while the detector still holds reset
    task automatic s_poc;
        supply_below_low <= 1'b1;
        repeat (10) @(posedge hclk);
        supply_below_low <= 1'b0;
        wait_rn(1'b1, 40);
        rdchk("cause_poc", PCL_CAUSE_OFS, 32'h0);
        rdchk("ctrl_poc", PCL_CTRL_OFS, 32'h0);
        ext_below_ref    <= 1'b0;
        supply_below_low <= 1'b1;
        wait_rn(1'b0, 1);
        repeat (10) @(posedge hclk);
        supply_below_low <= 1'b0;
        wait_rn(1'b1, 40);
    endtask : s_poc

    task automatic s_opt1;
        powerup_threshold_select <= 1'b1;
        supply_below_low         <= 1'b1;
        supply_below_high        <= 1'b1;
        repeat (10) @(posedge hclk);
        supply_below_low <= 1'b0;
        repeat (SMAX + 20) @(posedge hclk);
        bit_is("held_between", internal_reset_n, 1'b0);
        supply_below_high <= 1'b0;
        wait_rn(1'b1, SMAX + 10);
        supply_below_low  <= 1'b1;
        supply_below_high <= 1'b1;
        repeat (10) @(posedge hclk);
        supply_below_low <= 1'b0;
        repeat (2) @(posedge hclk);
        supply_below_high <= 1'b0;
        wait_rn(1'b1, SMAX + 10);
        chk("stab_wait", (n >= 8) ? 32'h1 : 32'h0, 32'h1);
        powerup_threshold_select <= 1'b0;
    endtask : s_opt1

    task automatic s_hreset;
        bus(1'b1, PCL_CTRL_OFS, 32'h86);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        wait_rn(1'b1, 40);
        rdchk("ctrl_hreset", PCL_CTRL_OFS, 32'h0);
    endtask : s_hreset

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ceiling far above the run's length
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            stop_test();
        end
    end

    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        {supply_below_low, supply_below_high, supply_below_level, ext_below_ref} = 4'h0;
        powerup_threshold_select = 1'b0;
        stop_mode                = 1'b0;
        err_count                = 0;
        comparisons              = 0;
        cycles                   = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        s_reset();
        s_flag();
        s_irq();
        s_lvreset();
        s_poc();
        s_opt1();
        s_hreset();
        stop_test();
    end
endmodule : pcl_top_tb
`default_nettype wire
